// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] rx;
    logic [1:0]  rs;
    logic [8:0]  ox;
  } usa_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        dma_req_in = 1'b0;
  logic [31:0] rd_data;
  logic [1:0]  resp;
  int          mismatches = 0;
  int          comparisons = 0;
  int          tx_flushes = 0;
  int          rx_flushes = 0;
  wire [7:0]   s_axi_awaddr, s_axi_araddr;
  wire [31:0]  s_axi_wdata, s_axi_rdata;
  wire [3:0]   s_axi_wstrb;
  wire [1:0]   s_axi_bresp, s_axi_rresp, rx_trigger, tx_empty_trigger;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire         port_rst_n, rts_ctrl, break_ctrl, queue_enable, dma_mode, transmit_halt;
  wire         tx_queue_flush, rx_queue_flush, dma_req_out;
  wire [8:0]   outs = {rts_ctrl, break_ctrl, dma_mode, queue_enable, rx_trigger,
                       tx_empty_trigger, transmit_halt};
  // Write address, data, read address, read data, response, controls after
  usa_row_t rows [13] = '{
    '{8'h8C, 32'h1, 8'h8C, 32'h1, 2'h0, 9'h100}, '{8'h90, 32'h1, 8'h90, 32'h1, 2'h0, 9'h180},
    '{8'h94, 32'h1, 8'h94, 32'h1, 2'h0, 9'h1C0}, '{8'h98, 32'h1, 8'h98, 32'h1, 2'h0, 9'h1E0},
    '{8'h9C, 32'h3, 8'h9C, 32'h3, 2'h0, 9'h1F8}, '{8'hA0, 32'h2, 8'hA0, 32'h2, 2'h0, 9'h1FC},
    '{8'hA4, 32'h1, 8'hA4, 32'h1, 2'h0, 9'h1FD}, '{8'h9C, 32'h1, 8'h08, 32'h69, 2'h0, 9'h1ED},
    '{8'h8C, 32'h0, 8'h10, 32'h0, 2'h0, 9'h0ED}, '{8'h0C, 32'h0, 8'h90, 32'h0, 2'h0, 9'h06D},
    '{8'h10, 32'h2, 8'h8C, 32'h1, 2'h0, 9'h16D}, '{8'h08, 32'h0, 8'h98, 32'h0, 2'h0, 9'h101},
    '{8'h50, 32'h1, 8'h50, 32'h0, 2'h2, 9'h101}};

  usa_shadow_regs dut_u (.*);
  usa_axi_host host_u (.*);

  // Free-running clock
  initial
    forever #2 aclk = ~aclk;

  // Count strobe cycles; a stuck or doubled pulse shows as a wrong count
  always @(posedge aclk)
  begin
    if (aresetn)
    begin
      tx_flushes <= tx_flushes + int'(tx_queue_flush);
      rx_flushes <= rx_flushes + int'(rx_queue_flush);
    end
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the hundred-odd cycles the tests need
  initial
  begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    summarize;
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("reset controls", outs, 9'h000);
    chk("port reset", port_rst_n, 1'b1);
    host_u.rd(8'h8C, rd_data, resp);
    chk("rts at reset", rd_data, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      host_u.wr(rows[i].wa, rows[i].wd, resp);
      chk("write resp", resp, rows[i].rs);
      host_u.rd(rows[i].ra, rd_data, resp);
      chk("read data", rd_data, rows[i].rx);
      chk("read resp", resp, rows[i].rs);
      chk("controls", outs, rows[i].ox);
    end
    host_u.rd(8'hF4, rd_data, resp);
    chk("build word", rd_data, 32'h0001_3822);
    // Write without the low byte lane must leave the bit alone
    host_u.s_axi_wstrb <= 4'hE;
    host_u.wr(8'h94, 32'h1, resp);
    host_u.s_axi_wstrb <= 4'hF;
    chk("no lane resp", resp, 2'h0);
    host_u.rd(8'h94, rd_data, resp);
    chk("no lane data", rd_data, 32'h0);
    $display("test table done");
    // Request, acknowledge, then re-arm after the request drops
    dma_req_in <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("dma request", dma_req_out, 1'b1);
    host_u.wr(8'hA8, 32'h1, resp);
    repeat (3) @(posedge aclk);
    chk("dma ack", dma_req_out, 1'b0);
    dma_req_in <= 1'b0;
    repeat (2) @(posedge aclk);
    dma_req_in <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("dma rearm", dma_req_out, 1'b1);
    $display("test dma done");
    // Flushes, then the whole-port reset
    host_u.wr(8'h88, 32'h6, resp);
    chk("flush resp", resp, 2'h0);
    host_u.wr(8'h88, 32'h1, resp);
    repeat (6) @(posedge aclk);
    chk("tx flush count", tx_flushes, 32'h1);
    chk("rx flush count", rx_flushes, 32'h1);
    chk("port release", port_rst_n, 1'b1);
    chk("cleared", outs, 9'h000);
    host_u.rd(8'h90, rd_data, resp);
    chk("break cleared", rd_data, 32'h0);
    $display("test soft reset done");
    summarize;
  end
endmodule // tb
`default_nettype wire

// ==== tb/usa_axi_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module usa_axi_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid, s_axi_rready,
  input  wire logic        s_axi_arready, s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Idle bus from time zero; full strobes, the block uses the low byte
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 11'h000;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wdata} <= 42'h0;
    s_axi_wstrb <= 4'hF;
  end
  // One write: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One read; no latency assumed, the bench watchdog ends a hang
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // usa_axi_host
`default_nettype wire

// ==== tb/usa_shadow_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module usa_shadow_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // Port controls
  input wire logic        port_rst_n,
  input wire logic        rts_ctrl,
  input wire logic        break_ctrl,
  input wire logic        queue_enable,
  input wire logic        transmit_halt,
  input wire logic        tx_queue_flush,
  input wire logic        dma_req_out,
  input wire logic [1:0]  rx_trigger
);
  logic [7:0]  wa;
  logic [31:0] wd;
  wire         ok = s_axi_bresp == 2'b00 && port_rst_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data of the write in flight; only one write at a time
  always @(posedge aclk)
    if (!aresetn)
    begin
      wa <= 8'h00;
      wd <= 32'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd <= s_axi_wdata;
    end
  // Alias writes land by the edge that raises the response
  a_rts_alias: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'h8C |-> rts_ctrl == wd[0])
    else $error("rts alias wrong");
  a_break_alias: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'h90 |-> break_ctrl == wd[0])
    else $error("break alias wrong");
  a_enable_alias: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'h98 |-> queue_enable == wd[0])
    else $error("enable alias wrong");
  a_rxtrig_alias: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'h9C |-> rx_trigger == wd[1:0])
    else $error("rx trigger alias wrong");
  a_halt_alias: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'hA4 |-> transmit_halt == wd[0])
    else $error("halt alias wrong");
  // Flush is a single pulse, reset release is bounded
  a_flush_pulse: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'h88 && wd[2] && !wd[0]
    |-> ##[0:1] (tx_queue_flush ##1 !tx_queue_flush))
    else $error("tx flush pulse wrong");
  a_soft_reset: assert property (
    $rose(s_axi_bvalid) && s_axi_bresp == 2'b00 && wa == 8'h88 && wd[0]
    |-> ##[0:1] !port_rst_n ##[1:4] port_rst_n)
    else $error("soft reset wrong");
  a_dma_ack: assert property (
    $rose(s_axi_bvalid) && ok && wa == 8'hA8 && wd[0]
    |-> ##[1:2] !dma_req_out)
    else $error("dma ack ignored");
endmodule // usa_shadow_props

bind usa_shadow_regs usa_shadow_props props_u (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .s_axi_awaddr   (s_axi_awaddr),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_wdata    (s_axi_wdata),
  .s_axi_bresp    (s_axi_bresp),
  .s_axi_bvalid   (s_axi_bvalid),
  .port_rst_n     (port_rst_n),
  .rts_ctrl       (rts_ctrl),
  .break_ctrl     (break_ctrl),
  .queue_enable   (queue_enable),
  .transmit_halt  (transmit_halt),
  .tx_queue_flush (tx_queue_flush),
  .dma_req_out    (dma_req_out),
  .rx_trigger     (rx_trigger)
);
`default_nettype wire

// ==== verilog/usa_consts.vh ====
`ifndef USA_CONSTS_VH
`define USA_CONSTS_VH

// Register byte offsets
`define USA_OFF_SOFT_RESET   8'h88
`define USA_OFF_RTS          8'h8C
`define USA_OFF_BREAK        8'h90
`define USA_OFF_DMA_MODE     8'h94
`define USA_OFF_FIFO_EN      8'h98
`define USA_OFF_RX_TRIG      8'h9C
`define USA_OFF_TX_TRIG      8'hA0
`define USA_OFF_HALT         8'hA4
`define USA_OFF_DMA_ACK      8'hA8
`define USA_OFF_BUILD        8'hF4
// Primary control registers, reachable here for access to the shared bits
`define USA_OFF_LINE_CTRL    8'h0C
`define USA_OFF_MODEM_CTRL   8'h10
`define USA_OFF_QUEUE_CTRL   8'h08

// Field positions
`define USA_SRR_RESET_BIT    0
`define USA_SRR_RXF_BIT      1
`define USA_SRR_TXF_BIT      2
`define USA_MCR_RTS_BIT      1
`define USA_LCR_BREAK_BIT    6
`define USA_FCR_EN_BIT       0
`define USA_FCR_RXF_BIT      1
`define USA_FCR_TXF_BIT      2
`define USA_FCR_DMA_BIT      3
`define USA_FCR_TET_LO       4
`define USA_FCR_RT_LO        6
`define USA_CPR_THRE_BIT     5
`define USA_CPR_SHADOW_BIT   11
`define USA_CPR_DMAX_BIT     13
`define USA_CPR_FIFO_LO      16

// Reset values
`define USA_RST_BYTE         8'h00
`define USA_RST_BIT          1'b0

// AXI responses
`define USA_RESP_OKAY        2'b00
`define USA_RESP_SLVERR      2'b10

// Reset synchroniser depth
`define USA_RST_SYNC_STAGES  3

`endif

// ==== verilog/usa_dma_ack.v ====
`timescale 1ns/100ps
`default_nettype none
`include "usa_consts.vh"

module usa_dma_ack
(
  // Clock and reset
  input  wire aclk,
  input  wire port_rst_n,
  // Requests
  input  wire dma_req_in,
  input  wire soft_ack,
  input  wire enable,
  // Gated request
  output reg  dma_req_out
);

  reg suppress;

  // Request held off from software ack until the source drops it
  always @(posedge aclk)
  begin
    if (!port_rst_n)
      suppress <= `USA_RST_BIT;
    else if (enable && soft_ack)
      suppress <= 1'b1;
    else if (!dma_req_in)
      suppress <= 1'b0;
  end

  // Output registered, one cycle behind the source
  always @(posedge aclk)
  begin
    if (!port_rst_n)
      dma_req_out <= `USA_RST_BIT;
    else
      dma_req_out <= dma_req_in && !suppress && !(enable && soft_ack);
  end

endmodule // usa_dma_ack
`default_nettype wire

// ==== verilog/usa_reset_sync.v ====
`timescale 1ns/100ps
`default_nettype none
`include "usa_consts.vh"

module usa_reset_sync
(
  // Clock and reset requests
  input  wire aclk,
  input  wire arst_req,
  // Port reset, active low
  output wire port_rst_n
);

  reg [`USA_RST_SYNC_STAGES-1:0] stage;

  // Async assert, synchronous release so no flop sees a runt release
  always @(posedge aclk or posedge arst_req)
  begin
    if (arst_req)
      stage <= {`USA_RST_SYNC_STAGES{1'b0}};
    else
      stage <= {stage[`USA_RST_SYNC_STAGES-2:0], 1'b1};
  end

  assign port_rst_n = stage[`USA_RST_SYNC_STAGES-1];

endmodule // usa_reset_sync
`default_nettype wire

// ==== verilog/usa_shadow_regs.v ====
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "usa_consts.vh"

module usa_shadow_regs
#(
  parameter HAS_FIFO                         = 1,
  parameter HAS_SHADOW                       = 1,
  parameter programmable_tx_threshold_option = 1,
  parameter extra_dma_handshake_option       = 1
)
(
  // Clock and bus reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Port core controls
  output wire        port_rst_n,
  output reg         rts_ctrl,
  output reg         break_ctrl,
  output reg         queue_enable,
  output reg         dma_mode,
  output reg  [1:0]  rx_trigger,
  output reg  [1:0]  tx_empty_trigger,
  output reg         transmit_halt,
  output reg         tx_queue_flush,
  output reg         rx_queue_flush,
  // DMA request path
  input  wire        dma_req_in,
  output wire        dma_req_out
);

  // Feature presence flags
  localparam [0:0] FIFO_ON   = (HAS_FIFO != 0);
  localparam [0:0] SHADOW_ON = (HAS_SHADOW != 0);
  localparam [0:0] THRE_ON   = (programmable_tx_threshold_option != 0);
  localparam [0:0] DMAX_ON   = (extra_dma_handshake_option != 0);
  localparam [0:0] AL_Q_ON   = FIFO_ON & SHADOW_ON;
  localparam [0:0] AL_T_ON   = FIFO_ON & THRE_ON & SHADOW_ON;

  // Write channel holding registers, then other internal state and wires
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         soft_reset_req;
  reg         dma_ack_pulse;
  reg  [7:0]  line_ctrl_rest;
  reg         modem_ctrl_rest;
  wire        wr_fire;
  wire        rd_fire;
  wire        lane0;
  wire [7:0]  wbyte;
  wire [7:0]  queue_ctrl_view;
  wire [7:0]  line_ctrl_view;
  wire [7:0]  modem_ctrl_view;
  wire [31:0] build_word;

  // Address decode, used for both reads and writes
  function addr_known;
    input [7:0] a;
    begin
      case (a)
        `USA_OFF_SOFT_RESET, `USA_OFF_RTS, `USA_OFF_BREAK, `USA_OFF_HALT,
        `USA_OFF_DMA_ACK, `USA_OFF_BUILD, `USA_OFF_LINE_CTRL,
        `USA_OFF_MODEM_CTRL, `USA_OFF_QUEUE_CTRL:
          addr_known = 1'b1;
        `USA_OFF_DMA_MODE, `USA_OFF_FIFO_EN, `USA_OFF_RX_TRIG:
          addr_known = AL_Q_ON;
        `USA_OFF_TX_TRIG:
          addr_known = AL_T_ON;
        default:
          addr_known = 1'b0;
      endcase
    end
  endfunction

  // Each channel taken once, in any order; stall while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        aw_now = aw_held || s_axi_awvalid;
  wire        w_now  = w_held || s_axi_wvalid;
  wire [7:0]  aw_cur = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] w_cur  = w_held ? w_data : s_axi_wdata;
  wire [3:0]  s_cur  = w_held ? w_strb : s_axi_wstrb;

  assign wr_fire = aw_now && w_now && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign lane0   = s_cur[0];
  assign wbyte   = w_cur[7:0];

  // Hold whichever channel arrived first
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= `USA_RST_BYTE;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Write response one cycle after both channels are in
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `USA_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_cur) ? `USA_RESP_OKAY : `USA_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Soft reset request; cleared only by the port reset it causes
  always @(posedge aclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
      soft_reset_req <= 1'b0;
    else if (wr_fire && lane0 && aw_cur == `USA_OFF_SOFT_RESET)
      soft_reset_req <= wbyte[`USA_SRR_RESET_BIT];
  end

  // Port reset: bus reset or soft reset, async assert, sync release
  usa_reset_sync u_rst
  (
    .aclk       (aclk),
    .arst_req   (soft_reset_req | !aresetn),
    .port_rst_n (port_rst_n)
  );

  // Shared control storage; primary and alias offsets hit the same flops
  always @(posedge aclk)
  begin
    if (!port_rst_n)
    begin
      rts_ctrl         <= `USA_RST_BIT;
      break_ctrl       <= `USA_RST_BIT;
      queue_enable     <= `USA_RST_BIT;
      dma_mode         <= `USA_RST_BIT;
      rx_trigger       <= 2'h0;
      tx_empty_trigger <= 2'h0;
      transmit_halt    <= `USA_RST_BIT;
      line_ctrl_rest   <= `USA_RST_BYTE;
      modem_ctrl_rest  <= `USA_RST_BIT;
    end
    else if (wr_fire && lane0)
    begin
      case (aw_cur)
        `USA_OFF_RTS:
          rts_ctrl <= wbyte[0];
        `USA_OFF_MODEM_CTRL:
        begin
          rts_ctrl        <= wbyte[`USA_MCR_RTS_BIT];
          modem_ctrl_rest <= wbyte[0];
        end
        `USA_OFF_BREAK:
          break_ctrl <= wbyte[0];
        `USA_OFF_LINE_CTRL:
        begin
          break_ctrl     <= wbyte[`USA_LCR_BREAK_BIT];
          line_ctrl_rest <= wbyte & 8'hBF;
        end
        `USA_OFF_DMA_MODE:
          if (AL_Q_ON)
            dma_mode <= wbyte[0];
        `USA_OFF_FIFO_EN:
          if (AL_Q_ON)
            queue_enable <= wbyte[0];
        `USA_OFF_RX_TRIG:
          if (AL_Q_ON)
            rx_trigger <= wbyte[1:0];
        `USA_OFF_TX_TRIG:
          if (AL_T_ON)
            tx_empty_trigger <= wbyte[1:0];
        `USA_OFF_QUEUE_CTRL:
          if (FIFO_ON)
          begin
            queue_enable <= wbyte[`USA_FCR_EN_BIT];
            dma_mode     <= wbyte[`USA_FCR_DMA_BIT];
            rx_trigger   <= wbyte[`USA_FCR_RT_LO+1:`USA_FCR_RT_LO];
            if (THRE_ON)
              tx_empty_trigger <= wbyte[`USA_FCR_TET_LO+1:`USA_FCR_TET_LO];
          end
        `USA_OFF_HALT:
          if (FIFO_ON)
            transmit_halt <= wbyte[0];
        default:
          transmit_halt <= transmit_halt;
      endcase
    end
  end

  // Flush strobes, one cycle, from reset register or queue control
  always @(posedge aclk)
  begin
    if (!port_rst_n)
    begin
      tx_queue_flush <= `USA_RST_BIT;
      rx_queue_flush <= `USA_RST_BIT;
      dma_ack_pulse  <= `USA_RST_BIT;
    end
    else
    begin
      tx_queue_flush <= FIFO_ON && wr_fire && lane0 &&
        ((aw_cur == `USA_OFF_SOFT_RESET && wbyte[`USA_SRR_TXF_BIT]) ||
         (aw_cur == `USA_OFF_QUEUE_CTRL && wbyte[`USA_FCR_TXF_BIT]));
      rx_queue_flush <= FIFO_ON && wr_fire && lane0 &&
        ((aw_cur == `USA_OFF_SOFT_RESET && wbyte[`USA_SRR_RXF_BIT]) ||
         (aw_cur == `USA_OFF_QUEUE_CTRL && wbyte[`USA_FCR_RXF_BIT]));
      dma_ack_pulse  <= wr_fire && lane0 && aw_cur == `USA_OFF_DMA_ACK &&
                        wbyte[0];
    end
  end

  // DMA request cut by software acknowledge
  usa_dma_ack u_dma
  (
    .aclk        (aclk),
    .port_rst_n  (port_rst_n),
    .dma_req_in  (dma_req_in),
    .soft_ack    (dma_ack_pulse),
    .enable      (DMAX_ON),
    .dma_req_out (dma_req_out)
  );

  // Primary register views; flush bits self-clear so read as zero
  assign queue_ctrl_view = {rx_trigger, tx_empty_trigger, dma_mode, 2'b00, queue_enable};
  assign line_ctrl_view  = line_ctrl_rest | {1'b0, break_ctrl, 6'h00};
  assign modem_ctrl_view = {6'h00, rts_ctrl, modem_ctrl_rest};
  assign build_word      = {8'h00, (FIFO_ON ? 8'h01 : 8'h00), 2'b00, DMAX_ON,
                            1'b1, SHADOW_ON, 5'h00, THRE_ON, 3'h0, 2'b10};

  // Read mux; write-only registers read zero
  function [31:0] read_word;
    input [7:0] a;
    begin
      case (a)
        `USA_OFF_RTS:        read_word = {31'h0, rts_ctrl};
        `USA_OFF_BREAK:      read_word = {31'h0, break_ctrl};
        `USA_OFF_DMA_MODE:   read_word = {31'h0, dma_mode};
        `USA_OFF_FIFO_EN:    read_word = {31'h0, queue_enable};
        `USA_OFF_RX_TRIG:    read_word = {30'h0, rx_trigger};
        `USA_OFF_TX_TRIG:    read_word = {30'h0, tx_empty_trigger};
        `USA_OFF_HALT:       read_word = {31'h0, transmit_halt};
        `USA_OFF_LINE_CTRL:  read_word = {24'h0, line_ctrl_view};
        `USA_OFF_MODEM_CTRL: read_word = {24'h0, modem_ctrl_view};
        `USA_OFF_QUEUE_CTRL: read_word = {24'h0, queue_ctrl_view};
        `USA_OFF_BUILD:      read_word = build_word;
        default:             read_word = 32'h00000000;
      endcase
    end
  endfunction

  // Read answer one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `USA_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word(s_axi_araddr);
      s_axi_rresp  <= addr_known(s_axi_araddr) ? `USA_RESP_OKAY : `USA_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // usa_shadow_regs
`default_nettype wire
